// ---- verilog/dasr_params.svh ----
// constants for the dual converter serial readout
// included by the package and the top module
`ifndef DASR_PARAMS_SVH
`define DASR_PARAMS_SVH
`define DASR_FRAME_LEN 16
`define DASR_RESULT_W 12
`define DASR_CHSEL_CYCLE 2
`define DASR_RD_LAG 3
`define DASR_CLK_PERIOD_NS 100
`define DASR_FIFO_DEPTH 16
`endif

// ---- verilog/dasr_pkg.sv ----
// types for the dual converter serial readout
// assumes dasr_params.svh on the include path
`include "dasr_params.svh"
package dasr_pkg;
    typedef enum logic [1:0] {
        DASR_IDLE = 2'b00,
        DASR_CONV = 2'b01
    } dasr_state_t;
    typedef logic [`DASR_RESULT_W-1:0] dasr_result_t;
endpackage : dasr_pkg

// ---- verilog/dasr_fifo.sv ----
// small flip-flop fifo with valid/ready on both sides
// assumes a single clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module dasr_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : dasr_fifo
`default_nettype wire

// ---- verilog/dasr_top.sv ----
// serial readout and sequencing for a dual 12-bit sampling converter
// assumes the converter clock is clk; all pins synchronous to it
//
// Summary of operation
// - 16-cycle frame: flags, 12 bits, two zeros
// - channel select latched at cycle two
// - routing high: line A only, B released
// - single-line: every second start ignored
// - channel mode high: auto alternate channels
// - both high: alternate, line A, skip starts
// - data valid after third clock past read
// - chip select low enables serial outputs
// - busy high for the sixteen-clock conversion
// - mode pins pick channel and routing scheme
`timescale 1ns/1ps
`default_nettype none
`include "dasr_params.svh"
module dasr_top #(
    parameter int FRAME_LEN = `DASR_FRAME_LEN,
    parameter int FIFO_DEPTH = `DASR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // host control pins
    input wire logic convert_start,
    input wire logic read_n,
    input wire logic chip_select_n,
    input wire logic channel_mode_pin,
    input wire logic output_routing_pin,
    input wire logic channel_select_pin,
    // conversion results from the two converters
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [`DASR_RESULT_W-1:0] result_a,
    input wire logic [`DASR_RESULT_W-1:0] result_b,
    // status and serial outputs
    output logic busy,
    output logic sample_channel,
    output logic serial_a,
    output logic serial_a_oe,
    output logic serial_b,
    output logic serial_b_oe
);
    localparam int RW = `DASR_RESULT_W;
    localparam int FW = 2 * RW + 4;
    localparam int CW = $clog2(FRAME_LEN + 1);

    // frame word: flag bits then result, top bit first
    function automatic logic [FRAME_LEN-1:0] dasr_frame(input logic ch, input logic pair,
                                                         input logic [RW-1:0] res);
        dasr_frame = {ch, pair, res, 2'b00};
    endfunction : dasr_frame

    dasr_pkg::dasr_state_t state_q, state_d;
    logic [CW-1:0] cyc_q;
    logic conv_prev_q;
    logic rd_prev_q;
    logic [1:0] rd_lag_q;
    logic rd_ok_q;
    logic chan_q;
    logic next_chan_q;
    logic skip_q;
    logic second_q;
    logic b_off_q;
    logic route_seen_q;
    logic [FRAME_LEN-1:0] sh_a_q, sh_b_q;
    logic [FRAME_LEN-1:0] hold_b_q;
    logic busy_q, sa_q, sb_q, sa_oe_q, sb_oe_q;

    // fifo between converter core and shifter
    logic f_valid;
    logic [FW-1:0] f_data;
    wire logic f_ready;
    wire logic start_edge = convert_start && !conv_prev_q;
    wire logic single_line = output_routing_pin;
    wire logic start_take = start_edge && (state_q == dasr_pkg::DASR_IDLE)
                            && !(single_line && skip_q);
    wire logic frame_end = (state_q == dasr_pkg::DASR_CONV) && (cyc_q == CW'(FRAME_LEN - 1));
    wire logic load_pair = start_take && !second_q;
    assign f_ready = load_pair;
    wire logic [RW-1:0] fa = f_data[RW-1:0];
    wire logic [RW-1:0] fb = f_data[2*RW-1:RW];
    wire logic fch = f_data[2*RW];
    wire logic chan_pick = channel_mode_pin ? ~next_chan_q : channel_select_pin;
    wire logic latch_chsel = (state_q == dasr_pkg::DASR_CONV)
                             && (cyc_q == CW'(`DASR_CHSEL_CYCLE - 1));
    wire logic rd_fall = !read_n && rd_prev_q;
    // a fresh read fall drops the drivers in the same edge, not one later
    wire logic drive_en = !chip_select_n && rd_ok_q && !rd_fall;
    // frame words; bit one leaves on the start edge, the shifters follow a cycle later
    wire logic [FRAME_LEN-1:0] new_a = dasr_frame(fch, 1'b0, f_valid ? fa : '0);
    wire logic [FRAME_LEN-1:0] new_b = dasr_frame(fch, 1'b1, f_valid ? fb : '0);
    wire logic [FRAME_LEN-1:0] first_a = load_pair ? new_a : hold_b_q;

    dasr_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data({3'b000, chan_q, result_b, result_a}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dasr_pkg::DASR_IDLE: begin
                if (start_take) begin
                    state_d = dasr_pkg::DASR_CONV;
                end
            end
            dasr_pkg::DASR_CONV: begin
                if (frame_end) begin
                    state_d = dasr_pkg::DASR_IDLE;
                end
            end
            default: state_d = dasr_pkg::DASR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= dasr_pkg::DASR_IDLE;
            cyc_q <= '0;
            conv_prev_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            conv_prev_q <= convert_start;
            cyc_q <= (state_q == dasr_pkg::DASR_CONV && !frame_end) ? cyc_q + 1'b1 : '0;
            busy_q <= (state_d == dasr_pkg::DASR_CONV);
        end
    end

    // channel choice for the following conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_q <= 1'b0;
            next_chan_q <= 1'b0;
        end else if (clk_en) begin
            if (latch_chsel && !second_q) begin
                next_chan_q <= chan_pick;
            end
            if (start_take && !second_q) begin
                chan_q <= next_chan_q;
            end
        end
    end

    // single-line pairing: second frame sends line B's result on A
    always_ff @(posedge clk) begin
        if (rst) begin
            skip_q <= 1'b0;
            second_q <= 1'b0;
        end else if (clk_en) begin
            if (frame_end) begin
                second_q <= single_line && !second_q;
            end
            if (start_edge && state_q == dasr_pkg::DASR_IDLE) begin
                skip_q <= single_line && !skip_q && !start_take ? 1'b0 : (single_line && start_take);
            end else if (start_edge && single_line && skip_q) begin
                skip_q <= 1'b0;
            end
        end
    end

    // release line B after the conversion following routing going high
    always_ff @(posedge clk) begin
        if (rst) begin
            route_seen_q <= 1'b0;
            b_off_q <= 1'b0;
        end else if (clk_en) begin
            if (!output_routing_pin) begin
                route_seen_q <= 1'b0;
                b_off_q <= 1'b0;
            end else begin
                route_seen_q <= 1'b1;
                if (route_seen_q && frame_end) begin
                    b_off_q <= 1'b1;
                end
            end
        end
    end

    // read strobe qualifies the drivers after the third clock
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_prev_q <= 1'b1;
            rd_lag_q <= '0;
            rd_ok_q <= 1'b0;
        end else if (clk_en) begin
            rd_prev_q <= read_n;
            if (rd_fall) begin
                rd_lag_q <= 2'(`DASR_RD_LAG - 1);
                rd_ok_q <= 1'b0;
            end else if (rd_lag_q != '0) begin
                rd_lag_q <= rd_lag_q - 1'b1;
                rd_ok_q <= (rd_lag_q == 2'h1);
            end else if (!read_n || rd_prev_q) begin
                rd_ok_q <= 1'b1;
            end
        end
    end

    // shift registers; empty fifo sends zero result
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_a_q <= '0;
            sh_b_q <= '0;
            hold_b_q <= '0;
        end else if (clk_en) begin
            if (load_pair) begin
                sh_a_q <= new_a;
                sh_b_q <= new_b;
                hold_b_q <= new_b;
            end else if (start_take) begin
                sh_a_q <= hold_b_q;
                sh_b_q <= '0;
            end else if (state_q == dasr_pkg::DASR_CONV) begin
                sh_a_q <= {sh_a_q[FRAME_LEN-2:0], 1'b0};
                sh_b_q <= {sh_b_q[FRAME_LEN-2:0], 1'b0};
            end
        end
    end

    // registered pins; line B idles released in single-line mode
    always_ff @(posedge clk) begin
        if (rst) begin
            sa_q <= 1'b0;
            sb_q <= 1'b0;
            sa_oe_q <= 1'b0;
            sb_oe_q <= 1'b0;
        end else if (clk_en) begin
            if (start_take) begin
                sa_q <= first_a[FRAME_LEN-1];
                sb_q <= load_pair && new_b[FRAME_LEN-1];
            end else begin
                sa_q <= (state_d == dasr_pkg::DASR_CONV) && sh_a_q[FRAME_LEN-2];
                sb_q <= (state_d == dasr_pkg::DASR_CONV) && sh_b_q[FRAME_LEN-2];
            end
            sa_oe_q <= drive_en;
            sb_oe_q <= drive_en && !b_off_q;
        end
    end

    assign busy = busy_q;
    assign sample_channel = chan_q;
    assign serial_a = sa_q;
    assign serial_b = sb_q;
    assign serial_a_oe = sa_oe_q;
    assign serial_b_oe = sb_oe_q;
endmodule : dasr_top
`default_nettype wire

// ---- sim/dasr_chk.sv ----
// port checker for the readout top
// bound onto every dasr_top instance
`timescale 1ns/1ps
`default_nettype none
module dasr_chk #(parameter int FRAME_LEN = 16) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic convert_start,
    input wire logic read_n,
    input wire logic chip_select_n,
    input wire logic output_routing_pin,
    input wire logic busy,
    input wire logic serial_a,
    input wire logic serial_a_oe,
    input wire logic serial_b,
    input wire logic serial_b_oe
);
    logic [4:0] cnt_q;
    // busy cycles so far; 0 is frame cycle one
    always_ff @(posedge clk) begin
        if (rst || !busy) cnt_q <= 5'h00;
        else cnt_q <= cnt_q + 5'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_busy_len; $fell(busy) |-> cnt_q == FRAME_LEN; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_busy_go; $rose(convert_start) && !busy && !output_routing_pin |=> busy; endproperty
    a_busy_go: assert property (p_busy_go) else $error("start not taken");
    property p_tail; busy && cnt_q >= 5'h0E && serial_a_oe |-> !serial_a; endproperty
    a_tail: assert property (p_tail) else $error("tail not zero");
    property p_bflag; busy && cnt_q == 5'h01 && serial_b_oe |-> serial_b; endproperty
    a_bflag: assert property (p_bflag) else $error("pair flag");
    property p_b_off; $fell(busy) && output_routing_pin && $past(output_routing_pin, 17) |=> !serial_b_oe; endproperty
    a_b_off: assert property (p_b_off) else $error("line b driven");
    property p_cs_off; chip_select_n && $past(chip_select_n) |-> !serial_a_oe && !serial_b_oe; endproperty
    a_cs_off: assert property (p_cs_off) else $error("driven unselected");
    property p_rd_lag; $fell(read_n) && !serial_a_oe |=> !serial_a_oe ##1 !serial_a_oe; endproperty
    a_rd_lag: assert property (p_rd_lag) else $error("data early");
    property p_rd_on; $fell(read_n) && !chip_select_n ##1 (!read_n && !chip_select_n)[*4] |-> serial_a_oe; endproperty
    a_rd_on: assert property (p_rd_on) else $error("data late");
endmodule : dasr_chk
bind dasr_top dasr_chk #(.FRAME_LEN(FRAME_LEN)) u_chk (.clk(clk), .rst(rst), .convert_start(convert_start),
    .read_n(read_n), .chip_select_n(chip_select_n), .output_routing_pin(output_routing_pin), .busy(busy),
    .serial_a(serial_a), .serial_a_oe(serial_a_oe), .serial_b(serial_b), .serial_b_oe(serial_b_oe));
`default_nettype wire

// ---- sim/dasr_host_rx.sv ----
// host serial receiver model
// samples both lines on rising edges while busy
`timescale 1ns/1ps
`default_nettype none
module dasr_host_rx (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // device pins
    input wire logic busy,
    input wire logic serial_a,
    input wire logic serial_a_oe,
    input wire logic serial_b,
    input wire logic serial_b_oe,
    // assembled frame
    output logic frame_valid,
    output logic [15:0] word_a,
    output logic [15:0] word_b,
    output logic b_ok
);
    logic [4:0] n_q;
    logic a_ok;
    always_ff @(posedge clk) begin
        frame_valid <= 1'b0;
        if (rst || !busy) begin
            n_q <= 5'h00;
            a_ok <= 1'b1;
            b_ok <= 1'b1;
        end else begin
            word_a <= {word_a[14:0], serial_a};
            word_b <= {word_b[14:0], serial_b};
            a_ok <= a_ok & serial_a_oe;
            b_ok <= b_ok & serial_b_oe;
            n_q <= n_q + 5'h01;
            // frames with line A undriven are dropped, not reported
            frame_valid <= (n_q == 5'h0F) & a_ok & serial_a_oe;
        end
    end
endmodule : dasr_host_rx
`default_nettype wire

// ---- sim/dasr_top_tb_top.sv ----
// bench for the readout: drives host pins and results
// host model frames are matched against a queue
`timescale 1ns/1ps
`default_nettype none
module dasr_top_tb_top;
    logic clk, rst, convert_start, read_n, chip_select_n, channel_mode_pin, output_routing_pin;
    logic channel_select_pin, result_valid, result_ready, busy, sample_channel;
    logic serial_a, serial_a_oe, serial_b, serial_b_oe, frame_valid, b_ok, ch, nx;
    dasr_pkg::dasr_result_t result_a, result_b;
    logic [15:0] word_a, word_b, rnd;
    logic [48:0] exp_q[$];
    logic [48:0] e;
    int fails = 0, tests_run = 0, cyc = 0;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    dasr_top dut (.clk(clk), .rst(rst), .clk_en(1'b1), .convert_start(convert_start), .read_n(read_n),
        .chip_select_n(chip_select_n), .channel_mode_pin(channel_mode_pin), .output_routing_pin(output_routing_pin),
        .channel_select_pin(channel_select_pin), .result_valid(result_valid), .result_ready(result_ready),
        .result_a(result_a), .result_b(result_b), .busy(busy), .sample_channel(sample_channel),
        .serial_a(serial_a), .serial_a_oe(serial_a_oe), .serial_b(serial_b), .serial_b_oe(serial_b_oe));
    dasr_host_rx u_host (.clk(clk), .rst(rst), .busy(busy), .serial_a(serial_a), .serial_a_oe(serial_a_oe),
        .serial_b(serial_b), .serial_b_oe(serial_b_oe), .frame_valid(frame_valid), .word_a(word_a),
        .word_b(word_b), .b_ok(b_ok));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic ok);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    task automatic tick;
        @(posedge clk);
        #10;
    endtask : tick
    task automatic push(input dasr_pkg::dasr_result_t a, input dasr_pkg::dasr_result_t b);
        result_valid = 1'b1;
        result_a = a;
        result_b = b;
        // ready only moves on edges, so its value here is what the next edge sees
        while (result_ready !== 1'b1) tick;
        tick;
        result_valid = 1'b0;
        tick;
    endtask : push
    // x: {check b, mask, a word, b word}; zero mask means no frame
    task automatic conv(input logic taken, input logic [48:0] x);
        if (x[47:32] != 16'h0000) exp_q.push_back(x);
        convert_start = 1'b1;
        tick;
        convert_start = 1'b0;
        tick;
        chk(busy === taken);
        repeat (17) tick;
    endtask : conv
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            end_sim;
        end
    end
    always @(posedge clk) begin
        if (frame_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0);
            end else begin
                e = exp_q.pop_front();
                chk(((word_a ^ e[31:16]) & e[47:32]) === 16'h0000);
                if (e[48]) chk(b_ok === 1'b1 && ((word_b ^ e[15:0]) & e[47:32]) === 16'h0000);
            end
        end
    end
    initial begin
        rnd = 16'h002C;
        {convert_start, channel_mode_pin, output_routing_pin, channel_select_pin, result_valid} = 5'h00;
        {read_n, chip_select_n, rst, ch, nx} = 5'h04;
        result_a = 12'h000;
        result_b = 12'h000;
        rst = 1'b1;
        repeat (5) tick;
        {rst, read_n} = 2'b00;
        repeat (5) tick;
        // a result is tagged with the channel in use when it was handed over
        for (int i = 0; i < 8; i++) begin
            channel_mode_pin = (i >= 4);
            channel_select_pin = rnd[0];
            push(rnd[11:0], rnd[15:4]);
            conv(1'b1, {1'b1, 16'hFFFF, ch, 1'b0, rnd[11:0], 2'h0, ch, 1'b1, rnd[15:4], 2'h0});
            ch = nx;
            nx = channel_mode_pin ? ~nx : channel_select_pin;
            chk(sample_channel === ch);
            rnd = lfsr(rnd);
        end
        $display("dual line done");
        output_routing_pin = 1'b1;
        for (int m = 0; m < 2; m++) begin
            channel_mode_pin = m[0];
            push(rnd[11:0], rnd[15:4]);
            conv(1'b1, {1'b0, 16'h7FFF, 2'b00, rnd[11:0], 18'h00000});
            conv(1'b0, '0);
            conv(1'b1, {1'b0, 16'h7FFF, 2'b01, rnd[15:4], 18'h00000});
            conv(1'b0, '0);
            chk(serial_b_oe === 1'b0);
            rnd = lfsr(rnd);
        end
        output_routing_pin = 1'b0;
        $display("single line done");
        for (int i = 0; i < 16; i++) begin
            push(rnd[11:0], rnd[15:4]);
            exp_q.push_back({1'b1, 16'h7FFF, 2'b00, rnd[11:0], 4'h1, rnd[15:4], 2'h0});
            rnd = lfsr(rnd);
        end
        tick;
        chk(result_ready === 1'b0);
        repeat (16) conv(1'b1, '0);
        conv(1'b1, {1'b1, 16'h7FFF, 32'h00004000});
        $display("buffer done");
        chip_select_n = 1'b1;
        conv(1'b1, '0);
        chk(serial_a_oe === 1'b0 && serial_b_oe === 1'b0);
        read_n = 1'b1;
        tick;
        {read_n, chip_select_n} = 2'b00;
        tick;
        chk(serial_a_oe === 1'b0);
        repeat (4) tick;
        chk(serial_a_oe === 1'b1);
        $display("select and read done");
        chk(exp_q.size() == 0);
        end_sim;
    end
endmodule : dasr_top_tb_top
`default_nettype wire
